// [common/ssm_pkg.sv]
package ssm_pkg;
   // --------------------------------------------------------------
   // register byte addresses
   // --------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL_HIGH = 8'h00;
   localparam logic [7:0] ADDR_CTRL_LOW = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   localparam logic [7:0] ADDR_ENABLE = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h14;
   localparam logic [7:0] ADDR_TX_DATA0 = 8'h18;
   localparam logic [7:0] ADDR_RX_DATA0 = 8'h1C;
   // --------------------------------------------------------------
   // reset values
   // --------------------------------------------------------------
   localparam logic [7:0] RST_CTRL_HIGH = 8'h08;
   localparam logic [7:0] RST_CTRL_LOW = 8'h00;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [7:0] RST_ENABLE = 8'h00;
   localparam logic [7:0] RST_CTRL_TWO = 8'h00;
   localparam logic [7:0] RST_DATA = 8'h00;
   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int B_MASTER = 7;
   localparam int B_SINGLE_LINE = 6;
   localparam int B_IDLE_OUT = 4;
   localparam int B_OUT_GUARD = 3;
   localparam int B_CLR_MODE = 7;
   localparam int B_PROTO = 6;
   localparam int B_SOFT_RST = 5;
   localparam int B_MSB_FIRST = 7;
   localparam int B_CPOL = 6;
   localparam int B_CPHA = 5;
   localparam int B_TX_ALLOW = 7;
   localparam int B_RX_ALLOW = 6;
   localparam int B_TX_DONE_FLAG_IE = 3;
   localparam int B_TEMPTY_IE = 2;
   localparam int B_RX_IE = 1;
   localparam int B_CONF_IE = 0;
   localparam int B_OVERRUN = 6;
   localparam int B_TDONE = 3;
   localparam int B_TEMPTY = 2;
   localparam int B_RFULL = 1;
   localparam int B_CONFLICT = 0;
   localparam int B_DONE_TIMING = 4;
   localparam int B_SEL_TIMING = 3;
   localparam int B_OUT_TIMING = 2;
   localparam logic [1:0] CS_AUTO = 2'h3;
   localparam logic [1:0] LEN_8BIT = 2'h0;
   localparam logic [3:0] FRAME_BITS = 4'h8;
   // divider select 011 gives peripheral clock / 16
   localparam logic [2:0] DIV_BY_16 = 3'h3;
   localparam logic [7:0] HALF_BIT_16 = 8'h08;

   typedef enum logic [1:0] {
      SSM_IDLE, SSM_LEAD, SSM_SHIFT, SSM_TRAIL
   } ssm_state_t;
endpackage : ssm_pkg

// [rtl/ssm_unit.sv]
// Summary of operation
// - master_select 1 makes the unit master driving the clock; 0 slave.
// - single_line_mode 0 uses separate data in and data out pins.
// - idle_out_level changes only when written with guard bit 0.
// - chip_select_function 11 drives chip select around each frame.
// - flag_clear_mode 0 clears flags when the data register is accessed.
// - soft_reset_bit 1 resets the serial engine; protocol_mode_sel 0 SPI.
// - frame_length_sel 00 gives 8-bit frames using only data register 0.
// - msb_first_sel 1 shifts most significant bit first both ways.
// - clock_idle_polarity 0 rests the clock high, pulsing low.
// - clock_phase_sel 0 changes output data on the first clock edge.
// - divider select 011 gives serial clock at peripheral clock / 16.
// - tx_allow bit 7 and rx_allow bit 6 enable transmit and receive.
// - four enable bits gate end, empty, receive/overrun, conflict requests.
// - status holds overrun 6, done 3, empty 2, full 1, conflict 0.
// - done_flag_timing 1 sets done only after the last bit leaves.
// - select and output-data timing bits choose early or late start.
// - transmit data register is eight bits, reset to zero.
// - receive data register is eight bits, reset to zero.
// - transmit write clears empty and done, loads shift_reg, sets empty.
// - a frame end with rx_allow set and full clear copies shift_in to receive data, sets full.
// - reading receive data clears the full flag.
// - done set when the last bit leaves with transmit buffer empty.
//
// The APB interface to the registers and the address map are this design's own decisions.
module ssm_unit
   import ssm_pkg::*;
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   output logic serial_clock_pin,
   output logic serial_clock_oe,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   input wire logic serial_data_in,
   output logic chip_select_pin_n,
   output logic chip_select_oe,
   // interrupt requests
   output logic tx_end_irq,
   output logic tx_empty_irq,
   output logic rx_full_irq,
   output logic overrun_irq,
   output logic conflict_irq
);
   // ---------------------------------------------------------------
   // registers and state
   // ---------------------------------------------------------------
   logic [7:0] control_high, control_low, mode_config, enable_config;
   logic [7:0] control_two, tx_data0, rx_data0, shift_reg;
   logic overrun_flag, tx_done_flag, tx_buf_empty_flag;
   logic rx_buf_full_flag, conflict_error_flag, tx_pending;
   logic [7:0] div_cnt;
   logic [3:0] bit_cnt;
   logic phase_hi;
   logic sclk_level, sdo_reg, cs_active;
   logic sdi_meta, sdi_sync;
   ssm_state_t state;

   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   wire logic wr_en = psel & penable & pwrite;
   wire logic rd_en = psel & penable & ~pwrite;
   wire logic wr_high = wr_en & (paddr == ADDR_CTRL_HIGH);
   wire logic wr_low = wr_en & (paddr == ADDR_CTRL_LOW);
   wire logic wr_mode = wr_en & (paddr == ADDR_MODE);
   wire logic wr_enable = wr_en & (paddr == ADDR_ENABLE);
   wire logic wr_status = wr_en & (paddr == ADDR_STATUS);
   wire logic wr_two = wr_en & (paddr == ADDR_CTRL_TWO);
   wire logic wr_tx = wr_en & (paddr == ADDR_TX_DATA0);
   wire logic rd_rx = rd_en & (paddr == ADDR_RX_DATA0);
   wire logic hit = (paddr[1:0] == 2'h0) && (paddr <= ADDR_RX_DATA0);

   // ---------------------------------------------------------------
   // configuration fields
   // ---------------------------------------------------------------
   wire logic is_master = control_high[B_MASTER];
   wire logic single_line = control_high[B_SINGLE_LINE];
   wire logic cs_auto = control_high[1:0] == CS_AUTO;
   wire logic clr_on_access = ~control_low[B_CLR_MODE];
   wire logic soft_rst = control_low[B_SOFT_RST];
   wire logic spi_mode = ~control_low[B_PROTO];
   wire logic len8 = control_low[1:0] == LEN_8BIT;
   wire logic msb_first = mode_config[B_MSB_FIRST];
   wire logic cpol = mode_config[B_CPOL];
   wire logic cpha = mode_config[B_CPHA];
   wire logic tx_allow = enable_config[B_TX_ALLOW];
   wire logic rx_allow = enable_config[B_RX_ALLOW];
   wire logic done_late = control_two[B_DONE_TIMING];
   wire logic sel_late = control_two[B_SEL_TIMING];
   wire logic out_late = control_two[B_OUT_TIMING];
   // frames only run in master, SPI, 8-bit, two-wire operation
   wire logic engine_ok = is_master & spi_mode & len8 & ~single_line
      & ~soft_rst;

   // ---------------------------------------------------------------
   // bit-rate divider: half period in pclk cycles
   // ---------------------------------------------------------------
   function automatic logic [7:0] half_period(input logic [2:0] sel);
      half_period = HALF_BIT_16 << (sel - DIV_BY_16);
      if (sel < DIV_BY_16) begin
         half_period = HALF_BIT_16 >> (DIV_BY_16 - sel);
      end
   endfunction : half_period

   wire logic [7:0] half_cnt = half_period(mode_config[2:0]);
   wire logic tick = (state != SSM_IDLE) && (div_cnt == half_cnt - 8'h01);
   wire logic lead_edge = tick & ~phase_hi; // first edge of bit
   wire logic trail_edge = tick & phase_hi; // second edge of bit
   wire logic last_bit = bit_cnt == FRAME_BITS - 4'h1;
   wire logic out_bit = msb_first ? shift_reg[7] : shift_reg[0];
   wire logic start_ok = (state == SSM_IDLE) & tx_pending & engine_ok
      & (tx_allow | rx_allow);
   wire logic frame_end = trail_edge & last_bit & (state == SSM_SHIFT);
   // next shift value: the incoming bit enters at the far end
   wire logic [7:0] shift_in = msb_first ? {shift_reg[6:0], sdi_sync}
      : {sdi_sync, shift_reg[7:1]};
   // done moment: early at the last edge, late after the trailing half
   wire logic done_set = tx_buf_empty_flag & ~tx_pending & (done_late
      ? (state == SSM_TRAIL && tick) : frame_end);

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_high <= RST_CTRL_HIGH;
         control_low <= RST_CTRL_LOW;
         mode_config <= RST_MODE;
         enable_config <= RST_ENABLE;
         control_two <= RST_CTRL_TWO;
      end else begin
         if (wr_high) begin
            control_high[7:5] <= pwdata[7:5];
            control_high[3:0] <= pwdata[3:0];
            if (!pwdata[B_OUT_GUARD]) begin
               control_high[B_IDLE_OUT] <= pwdata[B_IDLE_OUT];
            end
         end
         if (wr_low) control_low <= pwdata[7:0];
         if (wr_mode) mode_config <= pwdata[7:0];
         if (wr_enable) enable_config <= pwdata[7:0];
         if (wr_two) control_two <= pwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // data registers and flags; hardware set wins over clear
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_data0 <= RST_DATA;
         rx_data0 <= RST_DATA;
         tx_pending <= 1'b0;
         tx_buf_empty_flag <= 1'b1;
         tx_done_flag <= 1'b0;
         rx_buf_full_flag <= 1'b0;
         overrun_flag <= 1'b0;
         conflict_error_flag <= 1'b0;
      end else if (soft_rst) begin
         tx_pending <= 1'b0;
         tx_buf_empty_flag <= 1'b1;
         tx_done_flag <= 1'b0;
         rx_buf_full_flag <= 1'b0;
         overrun_flag <= 1'b0;
         conflict_error_flag <= 1'b0;
      end else begin
         if (wr_tx) begin
            tx_data0 <= pwdata[7:0];
            tx_pending <= 1'b1;
         end else if (start_ok) begin
            tx_pending <= 1'b0;
         end
         // write clears empty; the move to shift_reg sets it again
         if (start_ok) begin
            tx_buf_empty_flag <= 1'b1;
         end else if (wr_tx && clr_on_access) begin
            tx_buf_empty_flag <= 1'b0;
         end else if (wr_status && !pwdata[B_TEMPTY]) begin
            tx_buf_empty_flag <= 1'b0;
         end
         // done: at the last edge, or a half bit later when late
         if (done_set) begin
            tx_done_flag <= 1'b1;
         end else if (wr_tx || (wr_status && !pwdata[B_TDONE])) begin
            tx_done_flag <= 1'b0;
         end
         if (frame_end && rx_allow && !rx_buf_full_flag) begin
            // the byte handed over includes the bit sampled at this edge
            rx_data0 <= shift_in;
         end
         if (frame_end && rx_allow && !rx_buf_full_flag) begin
            rx_buf_full_flag <= 1'b1;
         end else if ((rd_rx && clr_on_access)
                      || (wr_status && !pwdata[B_RFULL])) begin
            rx_buf_full_flag <= 1'b0;
         end
         if (frame_end && rx_allow && rx_buf_full_flag) begin
            overrun_flag <= 1'b1;
         end else if (wr_status && !pwdata[B_OVERRUN]) begin
            overrun_flag <= 1'b0;
         end
         // a byte written over a waiting byte while a frame runs
         if (wr_tx && state != SSM_IDLE && tx_pending) begin
            conflict_error_flag <= 1'b1;
         end else if (wr_status && !pwdata[B_CONFLICT]) begin
            conflict_error_flag <= 1'b0;
         end
      end
   end


   // ---------------------------------------------------------------
   // input synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sdi_meta <= 1'b0;
         sdi_sync <= 1'b0;
      end else begin
         sdi_meta <= serial_data_in;
         sdi_sync <= sdi_meta;
      end
   end

   // ---------------------------------------------------------------
   // frame sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SSM_IDLE;
         div_cnt <= 8'h00;
         bit_cnt <= 4'h0;
         phase_hi <= 1'b0;
         shift_reg <= 8'h00;
         sdo_reg <= 1'b0;
         cs_active <= 1'b0;
         sclk_level <= 1'b0;
      end else if (soft_rst) begin
         state <= SSM_IDLE;
         div_cnt <= 8'h00;
         bit_cnt <= 4'h0;
         phase_hi <= 1'b0;
         cs_active <= 1'b0;
         sclk_level <= 1'b0;
      end else begin
         div_cnt <= tick || state == SSM_IDLE ? 8'h00 : div_cnt + 8'h01;
         case (state)
            SSM_IDLE: begin
               if (start_ok) begin
                  shift_reg <= tx_data0;
                  cs_active <= 1'b1;
                  // early output timing presents bit one at once
                  sdo_reg <= out_late ? sdo_reg
                     : (msb_first ? tx_data0[7] : tx_data0[0]);
                  state <= sel_late ? SSM_LEAD : SSM_SHIFT;
                  phase_hi <= 1'b0;
                  bit_cnt <= 4'h0;
               end
            end
            SSM_LEAD: begin
               // select asserted a whole bit before the first clock
               if (tick) state <= SSM_SHIFT;
            end
            SSM_SHIFT: begin
               if (tick) phase_hi <= ~phase_hi;
               if (lead_edge) begin
                  sclk_level <= 1'b1;
                  // phase 0 drives on the first edge, samples on second
                  if (!cpha && tx_allow) sdo_reg <= out_bit;
               end
               if (trail_edge) begin
                  sclk_level <= 1'b0;
                  // incoming bit joins the byte at the far end
                  shift_reg <= shift_in;
                  bit_cnt <= bit_cnt + 4'h1;
                  if (last_bit) state <= SSM_TRAIL;
               end
            end
            SSM_TRAIL: begin
               if (tick) begin
                  cs_active <= 1'b0;
                  state <= SSM_IDLE;
               end
            end
            default: state <= SSM_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // pins: clock rests at the inverse of the polarity bit, pulses the other way
   // ---------------------------------------------------------------
   assign serial_clock_pin = ~cpol ^ sclk_level;
   assign serial_clock_oe = is_master;
   assign serial_data_out = (state == SSM_IDLE)
      ? control_high[B_IDLE_OUT] : sdo_reg;
   assign serial_data_out_oe = is_master & tx_allow & ~single_line;
   assign chip_select_pin_n = ~cs_active;
   assign chip_select_oe = is_master & cs_auto;

   // ---------------------------------------------------------------
   // interrupt requests gated by enables
   // ---------------------------------------------------------------
   assign tx_end_irq = enable_config[B_TX_DONE_FLAG_IE] & tx_done_flag;
   assign tx_empty_irq = enable_config[B_TEMPTY_IE] & tx_buf_empty_flag;
   assign rx_full_irq = enable_config[B_RX_IE] & rx_buf_full_flag;
   assign overrun_irq = enable_config[B_RX_IE] & overrun_flag;
   assign conflict_irq = enable_config[B_CONF_IE] & conflict_error_flag;

   // ---------------------------------------------------------------
   // read mux and apb answer
   // ---------------------------------------------------------------
   wire logic [7:0] status_flags = {1'b0, overrun_flag, 2'h0, tx_done_flag,
      tx_buf_empty_flag, rx_buf_full_flag, conflict_error_flag};
   always_comb begin
      prdata = 32'h0000_0000;
      case (paddr)
         ADDR_CTRL_HIGH: prdata[7:0] = control_high;
         ADDR_CTRL_LOW: prdata[7:0] = control_low;
         ADDR_MODE: prdata[7:0] = mode_config;
         ADDR_ENABLE: prdata[7:0] = enable_config;
         ADDR_STATUS: prdata[7:0] = status_flags;
         ADDR_CTRL_TWO: prdata[7:0] = control_two;
         ADDR_TX_DATA0: prdata[7:0] = tx_data0;
         ADDR_RX_DATA0: prdata[7:0] = rx_data0;
         default: prdata = 32'h0000_0000;
      endcase
   end
   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;
endmodule : ssm_unit

// [verification/ssm_spi_slave.sv]
module ssm_spi_slave (
   // spi pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic miso,
   // bench side
   input wire logic [7:0] reply,
   output logic [7:0] got_byte,
   output int got_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rx;
   logic [7:0] tx;
   int nb;
   int idx;
   // latch the answer byte as the frame opens
   always @(negedge cs_n) tx <= reply;
   // shift out on the falling edge, scramble the line when released
   // an unknown select counts as deselected
   always @(negedge sclk or posedge cs_n) begin
      if (cs_n !== 1'b0) begin
         miso <= ~miso;
         idx <= 0;
      end else begin
         miso <= tx[7 - idx];
         idx <= idx + 1;
      end
   end
   // sample on the rising edge, hand the byte over at deselect
   always @(posedge sclk or posedge cs_n) begin
      if (cs_n !== 1'b0) begin
         if (nb != 0) begin
            got_byte <= rx;
            got_cnt <= got_cnt + 1;
         end
         nb <= 0;
      end else begin
         rx <= {rx[6:0], mosi};
         nb <= nb + 1;
      end
   end
endmodule : ssm_spi_slave

// [verification/ssm_unit_checker.sv]
module ssm_unit_checker (
   // apb side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // serial pins
   input wire logic serial_clock_pin,
   input wire logic serial_clock_oe,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire logic chip_select_pin_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] fall_cnt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // counts clock falls inside one frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) fall_cnt <= 4'h0;
      else if (chip_select_pin_n) fall_cnt <= 4'h0;
      else if ($fell(serial_clock_pin)) fall_cnt <= fall_cnt + 4'h1;
   end
   master_clk_a: assert property (!chip_select_pin_n |-> serial_clock_oe)
      else $error("clock not driven in frame");
   out_drive_a: assert property (!chip_select_pin_n |-> serial_data_out_oe)
      else $error("data out not driven in frame");
   idle_high_a: assert property (chip_select_pin_n |-> serial_clock_pin)
      else $error("clock not idle high");
   low_half_a: assert property ($fell(serial_clock_pin) |->
      !serial_clock_pin [*8] ##1 serial_clock_pin)
      else $error("low half not 8 cycles");
   high_half_a: assert property ($rose(serial_clock_pin) |->
      serial_clock_pin [*8])
      else $error("high half too short");
   sample_stable_a: assert property ($rose(serial_clock_pin) |->
      $stable(serial_data_out))
      else $error("data moved on sample edge");
   cs_lead_a: assert property ($fell(chip_select_pin_n) |->
      ##[1:20] $fell(serial_clock_pin))
      else $error("no clock after select");
   frame_bits_a: assert property ($rose(chip_select_pin_n) |->
      fall_cnt == 4'h8)
      else $error("frame not eight bits");
   apb_ready_a: assert property (psel && penable |-> pready)
      else $error("apb wait seen");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access");
endmodule : ssm_unit_checker
bind ssm_unit ssm_unit_checker ssm_unit_checker_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr),
   .serial_clock_pin(serial_clock_pin), .serial_clock_oe(serial_clock_oe),
   .serial_data_out(serial_data_out),
   .serial_data_out_oe(serial_data_out_oe),
   .chip_select_pin_n(chip_select_pin_n)
);

// [verification/ssm_unit_tb.sv]
module ssm_unit_tb
   import ssm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} ssm_exp_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, reply, got_byte, r3;
   logic [31:0] pwdata, prdata;
   logic sclk, sclk_oe, sdo, sdo_oe, sdi, cs_n, cs_oe;
   logic i_te, i_tx, i_rx, i_ov, i_ce;
   logic [15:0] rnd;
   int got_cnt, bad_count, tests_run, frames;
   ssm_exp_t rq[$];
   logic [7:0] pq[$];
   ssm_unit ssm_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_clock_pin(sclk), .serial_clock_oe(sclk_oe),
      .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
      .serial_data_in(sdi), .chip_select_pin_n(cs_n),
      .chip_select_oe(cs_oe), .tx_end_irq(i_te), .tx_empty_irq(i_tx),
      .rx_full_irq(i_rx), .overrun_irq(i_ov), .conflict_irq(i_ce));
   ssm_spi_slave ssm_spi_slave_i (.sclk(sclk), .cs_n(cs_n), .mosi(sdo),
      .miso(sdi), .reply(reply), .got_byte(got_byte), .got_cnt(got_cnt));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr
   task automatic bad(input string s);
      bad_count++;
      $display("BAD %0t %s", $time, s);
   endtask : bad
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) bad("pin level");
   endtask : chk
   task automatic final_report();
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // apb master, holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n == 20) bad("apb timeout");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
      @(negedge pclk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e,
                     input logic [7:0] m);
      rq.push_back('{{24'h0, e}, {24'hFFFFFF, m}, a > ADDR_RX_DATA0});
      apb(1'b0, a, 32'h0);
   endtask : rd
   task automatic wait_frames(input int n);
      int t;
      t = 0;
      while (got_cnt < n && t < 2000) begin
         t++;
         @(posedge pclk);
      end
      if (t == 2000) bad("frame timeout");
      repeat (4) @(negedge pclk);
   endtask : wait_frames
   task automatic send(input logic [7:0] d);
      pq.push_back(d);
      wr(ADDR_TX_DATA0, d);
   endtask : send
   // ------------------------------------------------------------
   // result watchers
   // ------------------------------------------------------------
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         tests_run++;
         if (rq.size() == 0) bad("unexpected read");
         else if ((prdata & rq[0].m) !== (rq[0].d & rq[0].m) ||
                  pslverr !== rq[0].e) bad("read data");
         if (rq.size() != 0) rq.delete(0);
      end
   end
   // bytes seen by the slave
   always @(got_cnt) begin
      #1;
      tests_run++;
      if (pq.size() == 0 || got_byte !== pq[0]) bad("serial byte");
      if (pq.size() != 0) pq.delete(0);
   end
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      #100000;
      bad("watchdog");
      final_report();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      reply = 8'h00;
      frames = 0;
      rnd = 16'h25A3;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_CTRL_HIGH, RST_CTRL_HIGH, 8'hFF);
      rd(ADDR_MODE, RST_MODE, 8'hFF);
      rd(ADDR_ENABLE, RST_ENABLE, 8'hFF);
      rd(ADDR_STATUS, 8'h04, 8'hFF);
      rd(ADDR_TX_DATA0, RST_DATA, 8'hFF);
      rd(ADDR_RX_DATA0, RST_DATA, 8'hFF);
      rd(8'h20, 8'h00, 8'hFF);
      chk({cs_n, sclk}, 8'h03);
      $display("test reset done");
      wr(ADDR_CTRL_LOW, 8'h00);
      wr(ADDR_MODE, {3'b100, 2'b00, DIV_BY_16});
      wr(ADDR_CTRL_TWO, 8'h10);
      wr(ADDR_CTRL_HIGH, 8'h93);
      chk(sdo, 1'b1);
      wr(ADDR_CTRL_HIGH, 8'h8B);
      chk(sdo, 1'b1);
      wr(ADDR_CTRL_HIGH, 8'h83);
      chk({sdo, sclk_oe, cs_oe}, 8'h03);
      wr(ADDR_ENABLE, 8'hC0);
      chk(sdo_oe, 1'b1);
      $display("test config done");
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         reply = rnd[15:8];
         send(rnd[7:0]);
         frames++;
         wait_frames(frames);
         chk({i_te, i_tx, i_rx}, 8'h00);
         rd(ADDR_STATUS, 8'h0E, 8'hFF);
         rd(ADDR_RX_DATA0, reply, 8'hFF);
         rd(ADDR_STATUS, 8'h0C, 8'hFF);
      end
      $display("test frames done");
      wr(ADDR_ENABLE, 8'hCF);
      chk({i_te, i_tx, i_rx, i_ov, i_ce}, 8'h18);
      rnd = lfsr(rnd);
      r3 = rnd[15:8];
      reply = r3;
      send(rnd[7:0]);
      rd(ADDR_STATUS, 8'h00, 8'h08);
      wait_frames(4);
      chk(i_rx, 1'b1);
      reply = ~r3;
      send(rnd[15:8]);
      wait_frames(5);
      rd(ADDR_STATUS, 8'h42, 8'h42);
      chk(i_ov, 1'b1);
      rd(ADDR_RX_DATA0, r3, 8'hFF);
      wr(ADDR_STATUS, 8'hBF);
      rd(ADDR_STATUS, 8'h00, 8'h40);
      $display("test overrun done");
      send(8'h5A);
      // a write over a waiting byte replaces it and flags a conflict
      wr(ADDR_TX_DATA0, 8'hC3);
      send(8'h99);
      rd(ADDR_STATUS, 8'h01, 8'h01);
      chk(i_ce, 1'b1);
      wait_frames(7);
      wr(ADDR_CTRL_LOW, 8'h20);
      rd(ADDR_STATUS, 8'h04, 8'hFF);
      wr(ADDR_CTRL_LOW, 8'h00);
      $display("test conflict and soft reset done");
      wr(ADDR_CTRL_TWO, 8'h18);
      reply = 8'h3C;
      send(8'hA5);
      wait_frames(8);
      rd(ADDR_RX_DATA0, 8'h3C, 8'hFF);
      $display("test late select done");
      final_report();
   end
endmodule : ssm_unit_tb
